// *** common/sif_pkg.sv ***
package sif_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_NS = 10;

    // least cycle count for a time in ns, never below one cycle
    function automatic int cyc_ceil(input int t_ns);
        int c;
        c = (t_ns + CLK_NS - 1) / CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return c;
    endfunction

    localparam int OCP_LONG_NS = 2200;
    localparam int OCP_SHORT_NS = 1200;
    localparam int BLANK0_NS = 1000;
    localparam int BLANK1_NS = 1500;
    localparam int BLANK2_NS = 2000;
    localparam int BLANK3_NS = 2500;
    localparam logic [7:0] OCP_LONG_CYC = 8'(cyc_ceil(OCP_LONG_NS));
    localparam logic [7:0] OCP_SHORT_CYC = 8'(cyc_ceil(OCP_SHORT_NS));
    localparam logic [7:0] BLANK0_CYC = 8'(cyc_ceil(BLANK0_NS));
    localparam logic [7:0] BLANK1_CYC = 8'(cyc_ceil(BLANK1_NS));
    localparam logic [7:0] BLANK2_CYC = 8'(cyc_ceil(BLANK2_NS));
    localparam logic [7:0] BLANK3_CYC = 8'(cyc_ceil(BLANK3_NS));

    // step input stability needed per tolerance code, in cycles
    localparam logic [2:0] TOL_CYC0 = 3'h1;
    localparam logic [2:0] TOL_CYC1 = 3'h2;
    localparam logic [2:0] TOL_CYC2 = 3'h4;
    localparam logic [2:0] TOL_CYC3 = 3'h6;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ADDR_LRN_STAT = 8'h02;
    localparam logic [7:0] ADDR_POR_STAT = 8'h03;
    localparam logic [7:0] ADDR_SDR = 8'h05;
    localparam logic [7:0] ADDR_FLP = 8'h06;
    localparam logic [7:0] ADDR_BSF = 8'h07;
    localparam logic [7:0] RST_SDR = 8'h06;
    localparam logic [7:0] RST_FLP = 8'h38;
    localparam logic [7:0] RST_BSF = 8'h49;
    localparam int POS_LEARN_OK = 4;
    localparam int POS_POR = 2;
    localparam logic [2:0] LOCK_ON = 3'h6;
    localparam logic [2:0] LOCK_OFF = 3'h3;

    // ****************************************
    // register layouts
    // ****************************************
    typedef struct packed {
        logic rotation_bit;
        logic step_bit;
        logic dir_src_sel;
        logic step_src_sel;
        logic [3:0] resolution_field;
    } sif_sdr_t;

    typedef struct packed {
        logic fault_clear_bit;
        logic [2:0] lock_field;
        logic overcurrent_deglitch_select;
        logic overcurrent_recovery_bit;
        logic overtemperature_recovery_bit;
        logic temperature_warning_report;
    } sif_flp_t;

    typedef struct packed {
        logic [1:0] blanking_field;
        logic stall_learn_bit;
        logic stall_detection_enable;
        logic stall_report_bit;
        logic pulse_filter_bypass;
        logic [1:0] pulse_tolerance_field;
    } sif_bsf_t;

endpackage

// *** design/sif_step_gen.sv ***
`timescale 1ns/1ps

module sif_step_gen (
    input wire logic clock_i,       // system clock
    input wire logic nrst_i,        // async reset, active low
    input wire logic step_pin_i,    // external step pin level
    input wire logic pin_src_i,     // 1: pin drives stepping
    input wire logic reg_step_i,    // register step request pulse
    input wire logic bypass_i,      // 1: no step filtering
    input wire logic [1:0] tol_i,   // filter tolerance code
    output logic step_o             // one-cycle indexer advance
);

    logic cand;
    logic lvl;
    logic [2:0] cnt;
    logic next_cand;
    logic next_lvl;
    logic [2:0] next_cnt;
    logic next_step;
    logic [2:0] need;

    // ****************************************
    // filter and pulse generation
    // ****************************************
    // pin must hold a level for need cycles before it is accepted
    always_comb begin
        case (tol_i)
            2'h0: need = sif_pkg::TOL_CYC0;
            2'h1: need = sif_pkg::TOL_CYC1;
            2'h2: need = sif_pkg::TOL_CYC2;
            default: need = sif_pkg::TOL_CYC3;
        endcase
        next_cand = cand;
        next_cnt = cnt;
        next_lvl = lvl;
        if (step_pin_i != cand) begin
            next_cand = step_pin_i;
            next_cnt = 3'h1;
        end else if (cnt < need) begin
            next_cnt = cnt + 3'h1;
        end
        if (bypass_i) begin
            next_lvl = step_pin_i;
        end else if (cnt >= need) begin
            next_lvl = cand;
        end
        // step source pick, register request wins over pin edge
        if (reg_step_i) begin
            next_step = 1'b1;
        end else if (pin_src_i) begin
            next_step = next_lvl && !lvl;
        end else begin
            next_step = 1'b0;
        end
    end

    // registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cand <= 1'b0;
            cnt <= 3'h0;
            lvl <= 1'b0;
            step_o <= 1'b0;
        end else begin
            cand <= next_cand;
            cnt <= next_cnt;
            lvl <= next_lvl;
            step_o <= next_step;
        end
    end

endmodule

// *** design/sif_fault_mon.sv ***
`timescale 1ns/1ps

module sif_fault_mon (
    input wire logic clock_i,       // system clock
    input wire logic nrst_i,        // async reset, active low
    input wire logic ocp_i,         // overcurrent detected
    input wire logic otsd_i,        // overtemperature shutdown
    input wire logic warn_i,        // temperature warning
    input wire logic stall_i,       // stall detected
    input wire logic uvlo_i,        // logic supply undervoltage
    input wire logic sleep_pulse_i, // sleep reset pulse
    input wire logic clear_i,       // fault clear pulse
    input wire logic ocp_retry_i,   // 1: overcurrent auto retry
    input wire logic ot_retry_i,    // 1: overtemp auto retry
    input wire logic warn_rep_i,    // report warnings
    input wire logic stall_en_i,    // stall detection on
    input wire logic stall_rep_i,   // report stall
    output logic ocp_fault_o,       // overcurrent fault state
    output logic otsd_fault_o,      // overtemp fault state
    output logic power_on_status_bit_o,            // power-on status
    output logic fault_n_o,         // fault pin output value
    output logic fault_n_oe_o       // fault pin drive enable
);

    logic next_ocp;
    logic next_otsd;
    logic next_power_on_status_bit;
    logic active;

    // ****************************************
    // fault latches
    // ****************************************
    // a new fault in the clear cycle wins over the clear
    always_comb begin
        if (ocp_retry_i) begin
            next_ocp = ocp_i;
        end else begin
            next_ocp = ocp_i || (ocp_fault_o && !clear_i);
        end
        if (ot_retry_i) begin
            next_otsd = otsd_i;
        end else begin
            next_otsd = otsd_i || (otsd_fault_o && !clear_i);
        end
        if (uvlo_i) begin
            next_power_on_status_bit = 1'b0;
        end else if (clear_i || sleep_pulse_i) begin
            next_power_on_status_bit = 1'b1;
        end else begin
            next_power_on_status_bit = power_on_status_bit_o;
        end
        active = next_ocp || next_otsd || (warn_rep_i && warn_i);
        active = active || (stall_en_i && stall_rep_i && stall_i);
    end

    // registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ocp_fault_o <= 1'b0;
            otsd_fault_o <= 1'b0;
            power_on_status_bit_o <= 1'b0;
            fault_n_o <= 1'b1;
            fault_n_oe_o <= 1'b0;
        end else begin
            ocp_fault_o <= next_ocp;
            otsd_fault_o <= next_otsd;
            power_on_status_bit_o <= next_power_on_status_bit;
            fault_n_o <= !active;
            fault_n_oe_o <= active;
        end
    end

endmodule

// *** design/sif_ctrl_regs.sv ***
`timescale 1ns/1ps

module sif_ctrl_regs (
    input wire logic clock_i,            // system clock, 100 MHz
    input wire logic nrst_i,             // async reset, active low
    input wire logic wr_i,               // register write strobe
    input wire logic rd_i,               // register read strobe
    input wire logic [7:0] addr_i,       // register address
    input wire logic [7:0] wdata_i,      // write data
    output logic [7:0] rdata_o,          // read data, next cycle
    input wire logic dir_pin_i,          // external direction pin
    input wire logic step_pin_i,         // external step pin
    input wire logic ocp_i,              // overcurrent detected
    input wire logic otsd_i,             // overtemp shutdown
    input wire logic warn_i,             // over/under temp warning
    input wire logic stall_i,            // stall detected
    input wire logic uvlo_i,             // logic supply undervoltage
    input wire logic sleep_pulse_i,      // sleep reset pulse
    input wire logic learn_done_i,       // stall learning finished
    input wire logic learn_ok_i,         // learning succeeded
    output logic dir_o,                  // 1 forward, 0 reverse
    output logic step_o,                 // indexer advance pulse
    output logic [3:0] resolution_o,     // resolution_field code
    output logic fault_clear_o,          // fault clear pulse
    output logic locked_o,               // settings locked
    output logic [7:0] ocp_deglitch_o,   // deglitch time, cycles
    output logic [7:0] blank_cyc_o,      // blanking time, cycles
    output logic stall_enable_o,         // stall detection on
    output logic stall_learn_o,          // learning in progress
    output logic ocp_fault_o,            // overcurrent fault
    output logic otsd_fault_o,           // overtemp fault
    output logic fault_out_n_o,          // fault pin value
    output logic fault_out_n_oe_o        // fault pin drive enable
);

    sif_pkg::sif_sdr_t sdr;
    sif_pkg::sif_flp_t flp;
    sif_pkg::sif_bsf_t bsf;
    sif_pkg::sif_sdr_t next_sdr;
    sif_pkg::sif_flp_t next_flp;
    sif_pkg::sif_bsf_t next_bsf;
    sif_pkg::sif_sdr_t wsdr;
    sif_pkg::sif_flp_t wflp;
    sif_pkg::sif_bsf_t wbsf;
    logic learn_ok;
    logic next_learn_ok;
    logic next_fclr;
    logic locked;
    logic wr_sdr;
    logic wr_flp;
    logic wr_bsf;
    logic reg_step_req;
    logic power_on_status_bit;
    logic next_dir;
    logic [7:0] next_dg;
    logic [7:0] next_blank;
    logic [7:0] next_rdata;

    assign wsdr = sif_pkg::sif_sdr_t'(wdata_i);
    assign wflp = sif_pkg::sif_flp_t'(wdata_i);
    assign wbsf = sif_pkg::sif_bsf_t'(wdata_i);
    assign locked = (flp.lock_field == sif_pkg::LOCK_ON);

    // ****************************************
    // write decode
    // ****************************************
    // locked write blocking
    assign wr_sdr = wr_i && (addr_i == sif_pkg::ADDR_SDR) && !locked;
    assign wr_bsf = wr_i && (addr_i == sif_pkg::ADDR_BSF) && !locked;
    assign wr_flp = wr_i && (addr_i == sif_pkg::ADDR_FLP);
    assign reg_step_req = wr_sdr && wsdr.step_bit && wsdr.step_src_sel;

    // ****************************************
    // control registers
    // ****************************************
    always_comb begin
        next_sdr = sdr;
        next_flp = flp;
        next_bsf = bsf;
        next_learn_ok = learn_ok;
        next_fclr = 1'b0;
        if (wr_sdr) begin
            next_sdr = wsdr;
        end
        next_sdr.step_bit = 1'b0;
        if (wr_flp) begin
            if (!locked) begin
                next_flp = wflp;
                next_flp.lock_field = (wflp.lock_field == sif_pkg::LOCK_ON) ?
                                      sif_pkg::LOCK_ON : flp.lock_field;
            end else if (wflp.lock_field == sif_pkg::LOCK_OFF) begin
                next_flp.lock_field = sif_pkg::LOCK_OFF;
            end
            next_fclr = wflp.fault_clear_bit;
        end
        next_flp.fault_clear_bit = 1'b0;
        if (learn_done_i) begin
            next_bsf.stall_learn_bit = 1'b0;
        end
        if (wr_bsf) begin
            next_bsf = wbsf;
            if (wbsf.stall_learn_bit) begin
                next_learn_ok = 1'b0;
            end
        end
        if (learn_done_i && bsf.stall_learn_bit && learn_ok_i) begin
            next_learn_ok = 1'b1;
        end
    end

    // registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdr <= sif_pkg::sif_sdr_t'(sif_pkg::RST_SDR);
            flp <= sif_pkg::sif_flp_t'(sif_pkg::RST_FLP);
            bsf <= sif_pkg::sif_bsf_t'(sif_pkg::RST_BSF);
            learn_ok <= 1'b0;
            fault_clear_o <= 1'b0;
            locked_o <= 1'b0;
        end else begin
            sdr <= next_sdr;
            flp <= next_flp;
            bsf <= next_bsf;
            learn_ok <= next_learn_ok;
            fault_clear_o <= next_fclr;
            locked_o <= (next_flp.lock_field == sif_pkg::LOCK_ON);
        end
    end

    // ****************************************
    // configuration outputs
    // ****************************************
    always_comb begin
        next_dir = sdr.dir_src_sel ? sdr.rotation_bit : dir_pin_i;
        next_dg = flp.overcurrent_deglitch_select ? sif_pkg::OCP_LONG_CYC :
                  sif_pkg::OCP_SHORT_CYC;
        case (bsf.blanking_field)
            2'h0: next_blank = sif_pkg::BLANK0_CYC;
            2'h1: next_blank = sif_pkg::BLANK1_CYC;
            2'h2: next_blank = sif_pkg::BLANK2_CYC;
            default: next_blank = sif_pkg::BLANK3_CYC;
        endcase
    end

    // registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dir_o <= 1'b0;
            ocp_deglitch_o <= sif_pkg::OCP_LONG_CYC;
            blank_cyc_o <= sif_pkg::BLANK1_CYC;
            resolution_o <= sif_pkg::RST_SDR[3:0];
            stall_enable_o <= 1'b0;
            stall_learn_o <= 1'b0;
        end else begin
            dir_o <= next_dir;
            ocp_deglitch_o <= next_dg;
            blank_cyc_o <= next_blank;
            resolution_o <= sdr.resolution_field;
            stall_enable_o <= bsf.stall_detection_enable;
            stall_learn_o <= bsf.stall_learn_bit;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        next_rdata = rdata_o;
        if (rd_i) begin
            case (addr_i)
                sif_pkg::ADDR_SDR: next_rdata = sdr;
                sif_pkg::ADDR_FLP: next_rdata = flp;
                sif_pkg::ADDR_BSF: next_rdata = bsf;
                sif_pkg::ADDR_LRN_STAT: next_rdata = 8'(learn_ok) << sif_pkg::POS_LEARN_OK;
                sif_pkg::ADDR_POR_STAT: next_rdata = 8'(power_on_status_bit) << sif_pkg::POS_POR;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // registers
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // ****************************************
    // submodules
    // ****************************************
    // tolerance drives filter
    sif_step_gen u_step (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .step_pin_i(step_pin_i),
        .pin_src_i(!sdr.step_src_sel),
        .reg_step_i(reg_step_req),
        .bypass_i(bsf.pulse_filter_bypass),
        .tol_i(bsf.pulse_tolerance_field),
        .step_o(step_o)
    );

    sif_fault_mon u_fault (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .ocp_i(ocp_i),
        .otsd_i(otsd_i),
        .warn_i(warn_i),
        .stall_i(stall_i),
        .uvlo_i(uvlo_i),
        .sleep_pulse_i(sleep_pulse_i),
        .clear_i(fault_clear_o),
        .ocp_retry_i(flp.overcurrent_recovery_bit),
        .ot_retry_i(flp.overtemperature_recovery_bit),
        .warn_rep_i(flp.temperature_warning_report),
        .stall_en_i(bsf.stall_detection_enable),
        .stall_rep_i(bsf.stall_report_bit),
        .ocp_fault_o(ocp_fault_o),
        .otsd_fault_o(otsd_fault_o),
        .power_on_status_bit_o(power_on_status_bit),
        .fault_n_o(fault_out_n_o),
        .fault_n_oe_o(fault_out_n_oe_o)
    );

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    property p_dir_src;
        $past(nrst_i) |-> dir_o == $past(sdr.dir_src_sel ? sdr.rotation_bit : dir_pin_i);
    endproperty
    a_dir_src: assert property (p_dir_src) else $error("direction source wrong");

    property p_reg_step;
        wr_i && !locked && addr_i == sif_pkg::ADDR_SDR && wsdr.step_bit && wsdr.step_src_sel
            |=> step_o;
    endproperty
    a_reg_step: assert property (p_reg_step) else $error("register step lost");

    property p_step_clear;
        rd_i && addr_i == sif_pkg::ADDR_SDR |=> !rdata_o[6];
    endproperty
    a_step_clear: assert property (p_step_clear) else $error("step bit read as one");

    property p_lock_hold;
        locked && wr_i && addr_i == sif_pkg::ADDR_SDR |=> $stable(sdr);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked write took effect");

    property p_unlock;
        locked && wr_i && addr_i == sif_pkg::ADDR_FLP && wflp.lock_field == sif_pkg::LOCK_OFF
            |=> !locked_o;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock ignored");

    property p_lock_codes;
        flp.lock_field == sif_pkg::LOCK_ON || flp.lock_field == sif_pkg::LOCK_OFF;
    endproperty
    a_lock_codes: assert property (p_lock_codes) else $error("illegal lock code stored");

    property p_fclr;
        wr_i && addr_i == sif_pkg::ADDR_FLP && wflp.fault_clear_bit
            |=> fault_clear_o && !flp.fault_clear_bit;
    endproperty
    a_fclr: assert property (p_fclr) else $error("fault clear pulse missing");

    property p_deglitch;
        ##1 ocp_deglitch_o == ($past(flp.overcurrent_deglitch_select) ?
            sif_pkg::OCP_LONG_CYC : sif_pkg::OCP_SHORT_CYC);
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("deglitch count wrong");

    property p_blank_short;
        bsf.blanking_field == 2'h0 |=> blank_cyc_o == sif_pkg::BLANK0_CYC;
    endproperty
    a_blank_short: assert property (p_blank_short) else $error("blanking count wrong");

    property p_learn_done;
        learn_done_i && !wr_bsf |=> !bsf.stall_learn_bit ##1 !stall_learn_o || bsf.stall_learn_bit;
    endproperty
    a_learn_done: assert property (p_learn_done) else $error("learn bit stuck");

    property p_power_on_status_bit;
        uvlo_i |=> !power_on_status_bit;
    endproperty
    a_power_on_status_bit: assert property (p_power_on_status_bit) else $error("power-on bit not cleared");

    c_reg_step: cover property (reg_step_req ##1 step_o);
    c_lock_cycle: cover property (locked_o ##[1:20] !locked_o);
    c_learn_ok: cover property (stall_learn_o ##[1:50] learn_ok);

endmodule

// *** bench/sif_host_model.sv ***
`timescale 1ns/1ps
module sif_host_model (
    input wire logic clock_i, // system clock
    input wire logic [7:0] rdata_i, // read data
    output logic wr_o, // write strobe
    output logic rd_o, // read strobe
    output logic [7:0] addr_o, // register address
    output logic [7:0] wdata_o, // write data
    output logic step_pin_o, // step pin level
    output logic dir_pin_o // direction pin level
);
    // idle bus, direction pin high
    initial begin
        {wr_o, rd_o, step_pin_o, dir_pin_o} = 4'h1;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        {wr_o, addr_o, wdata_o} <= {1'b1, a, d};
        @(posedge clock_i);
        {wr_o, wdata_o} <= {1'b0, ~d};
    endtask
    // read data is taken once the strobe edge has passed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        {rd_o, addr_o} <= {1'b1, a};
        @(posedge clock_i);
        rd_o <= 1'b0;
        #1;
        d = rdata_i;
    endtask
    // step pin high for six cycles
    task automatic pulse();
        @(posedge clock_i);
        step_pin_o <= 1'b1;
        repeat (6) @(posedge clock_i);
        step_pin_o <= 1'b0;
    endtask
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    // ****************************************
    // bench signals
    // ****************************************
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] q;
        logic [7:0] blk;
        logic [3:0] res;
    } sif_row_t;
    sif_row_t rows [7] = '{{8'h05, 8'h0A, 8'h0A, 8'h96, 4'hA},
        {8'h05, 8'h50, 8'h10, 8'h96, 4'h0}, {8'h07, 8'h09, 8'h09, 8'h64, 4'h0},
        {8'h07, 8'h89, 8'h89, 8'hC8, 4'h0}, {8'h07, 8'hC9, 8'hC9, 8'hFA, 4'h0},
        {8'h07, 8'h49, 8'h49, 8'h96, 4'h0}, {8'h05, 8'h03, 8'h03, 8'h96, 4'h3}};
    logic [7:0] ra [5] = '{8'h05, 8'h06, 8'h07, 8'h04, 8'h03};
    logic [7:0] rv [5] = '{8'h06, 8'h38, 8'h49, 8'h00, 8'h00};
    logic clock_i = 1'b0;
    logic nrst_i, wr_i, rd_i, dir_pin_i, step_pin_i, ocp_i, otsd_i, warn_i, stall_i;
    logic uvlo_i, sleep_pulse_i, learn_done_i, learn_ok_i, dir_o, step_o, fault_clear_o;
    logic locked_o, stall_enable_o, stall_learn_o, ocp_fault_o, otsd_fault_o;
    logic fault_out_n_o, fault_out_n_oe_o;
    logic [7:0] addr_i, wdata_i, rdata_o, ocp_deglitch_o, blank_cyc_o, v, c;
    logic [3:0] resolution_o;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    sif_ctrl_regs i_sif_ctrl_regs (.clock_i, .nrst_i, .wr_i, .rd_i, .addr_i, .wdata_i,
        .rdata_o, .dir_pin_i, .step_pin_i, .ocp_i, .otsd_i, .warn_i, .stall_i, .uvlo_i,
        .sleep_pulse_i, .learn_done_i, .learn_ok_i, .dir_o, .step_o, .resolution_o,
        .fault_clear_o, .locked_o, .ocp_deglitch_o, .blank_cyc_o, .stall_enable_o,
        .stall_learn_o, .ocp_fault_o, .otsd_fault_o, .fault_out_n_o, .fault_out_n_oe_o);
    sif_host_model i_sif_host_model (.clock_i, .rdata_i(rdata_o), .wr_o(wr_i),
        .rd_o(rd_i), .addr_o(addr_i), .wdata_o(wdata_i), .step_pin_o(step_pin_i),
        .dir_pin_o(dir_pin_i));
    // 100 MHz clock
    always #5 clock_i = ~clock_i;
    // hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    // ****************************************
    // helpers
    // ****************************************
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        i_sif_host_model.wr(a, d);
    endtask
    task automatic r(input logic [7:0] a);
        i_sif_host_model.rd(a, v);
    endtask
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // counts indexer advances over n cycles
    task automatic steps(input int n);
        c = 8'h00;
        repeat (n) begin
            @(negedge clock_i);
            if (step_o === 1'b1) c = c + 8'h01;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        {nrst_i, otsd_i, warn_i, stall_i, uvlo_i} = 5'h00;
        {ocp_i, sleep_pulse_i, learn_done_i, learn_ok_i} = 4'h0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        foreach (rows[i]) begin
            w(rows[i].a, rows[i].d);
            r(rows[i].a);
            cmp(v, rows[i].q);
            cmp(blank_cyc_o, rows[i].blk);
            cmp(8'(resolution_o), 8'(rows[i].res));
        end
        $display("done: register rows");
        @(posedge clock_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        nrst_i <= 1'b1;
        foreach (ra[i]) begin
            r(ra[i]);
            cmp(v, rv[i]);
        end
        cmp(ocp_deglitch_o, 8'hDC);
        cmp(8'(dir_o), 8'h01);
        $display("done: reset");
        w(8'h05, 8'h46);
        steps(6);
        cmp(c, 8'h00);
        fork
            i_sif_host_model.pulse();
            steps(12);
        join
        cmp(c, 8'h01);
        w(8'h05, 8'h56);
        steps(4);
        cmp(c, 8'h01);
        fork
            i_sif_host_model.pulse();
            steps(12);
        join
        cmp(c, 8'h00);
        w(8'h05, 8'h26);
        r(8'h05);
        cmp(8'(dir_o), 8'h00);
        w(8'h05, 8'hA6);
        r(8'h05);
        cmp(8'(dir_o), 8'h01);
        $display("done: stepping");
        w(8'h06, 8'h68);
        w(8'h05, 8'h0A);
        r(8'h05);
        cmp(v, 8'hA6);
        cmp(8'(locked_o), 8'h01);
        w(8'h06, 8'h30);
        w(8'h06, 8'h30);
        r(8'h06);
        cmp(v, 8'h30);
        cmp(ocp_deglitch_o, 8'h78);
        $display("done: lock");
        @(posedge clock_i);
        {ocp_i, uvlo_i} <= 2'h3;
        repeat (3) @(posedge clock_i);
        {ocp_i, uvlo_i} <= 2'h0;
        repeat (3) @(negedge clock_i);
        cmp({6'h00, ocp_fault_o, fault_out_n_oe_o}, 8'h03);
        w(8'h06, 8'hB0);
        @(negedge clock_i);
        cmp(8'(fault_clear_o), 8'h01);
        repeat (2) @(negedge clock_i);
        r(8'h06);
        cmp({v[7:1], ocp_fault_o}, 8'h30);
        r(8'h03);
        cmp(v & 8'h04, 8'h04);
        w(8'h07, 8'h69);
        repeat (3) @(negedge clock_i);
        cmp(8'(stall_learn_o), 8'h01);
        @(posedge clock_i);
        {learn_done_i, learn_ok_i} <= 2'h3;
        @(posedge clock_i);
        {learn_done_i, learn_ok_i} <= 2'h0;
        r(8'h07);
        cmp(v, 8'h49);
        r(8'h02);
        cmp(v & 8'h10, 8'h10);
        $display("done: faults and learning");
        w(8'h06, 8'h33);
        w(8'h07, 8'h59);
        @(posedge clock_i);
        {otsd_i, stall_i} <= 2'h3;
        repeat (2) @(negedge clock_i);
        cmp({6'h00, otsd_fault_o, fault_out_n_o}, 8'h02);
        cmp(8'(stall_enable_o), 8'h01);
        @(posedge clock_i);
        otsd_i <= 1'b0;
        repeat (2) @(negedge clock_i);
        cmp({6'h00, otsd_fault_o, fault_out_n_o}, 8'h00);
        w(8'h07, 8'h51);
        repeat (2) @(negedge clock_i);
        cmp(8'(fault_out_n_o), 8'h01);
        @(posedge clock_i);
        {stall_i, warn_i} <= 2'h1;
        repeat (2) @(negedge clock_i);
        cmp(8'(fault_out_n_o), 8'h00);
        $display("done: retry and reporting");
        end_of_test();
    end
endmodule
